// file: e1_ja_mem.sv
`timescale 1ns/100ps
module e1_ja_mem
  import e1_ja_pkg::*;
#(
  parameter int W     = WORD_W,
  parameter int DEPTH = MAX_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rd;
  } mem_s;

  mem_s cur;
  mem_s next_cur;

  // Storage write and registered read
  always_comb begin
    next_cur = cur;
    if (wr_en) begin
      next_cur.mem[wr_addr] = wr_data;
    end
    next_cur.rd = cur.mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign rd_data = cur.rd;

endmodule : e1_ja_mem

// file: e1_ja_pkg.sv
package e1_ja_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_STATUS   = 5'h04;
  localparam logic [4:0] OFS_INT_STAT = 5'h08;
  localparam logic [4:0] OFS_INT_MASK = 5'h0c;

  // Control register fields
  localparam int CTL_ATTEN_EN  = 0;
  localparam int CTL_SIDE_TX   = 1;
  localparam int CTL_CENTRE    = 2;
  localparam int CTL_LOSS_SEL  = 3;
  localparam int CTL_EQ_AUTO   = 4;
  localparam int CTL_DEPTH_LSB = 8;
  localparam int CTL_GAIN_LSB  = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0700;

  // Status register fields
  localparam int ST_LOS      = 0;
  localparam int ST_CENTRING = 1;
  localparam int ST_FRAME    = 2;
  localparam int ST_CORR     = 3;
  localparam int ST_FILL_LSB = 8;
  localparam int ST_GAIN_LSB = 16;

  // Interrupt status bits
  localparam int INT_LOS     = 0;
  localparam int INT_CORR    = 1;
  localparam int INT_CENTRED = 2;
  localparam int INT_XRUN    = 3;
  localparam int INT_W       = 4;

  // FIFO geometry
  localparam int WORD_W      = 2;
  localparam int MAX_DEPTH   = 128;
  localparam int DEPTH_STEP  = 16;
  localparam int GUARD_BITS  = 4;
  localparam logic [7:0] GUARD_WORDS = 8'(GUARD_BITS / WORD_W);

  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CLK_KHZ        = 40000;
  localparam int BIT_RATE_KHZ   = 2048;
  localparam int LOS_TIME_NS    = 1000000;
  localparam int LOS_CYCLES     =
    (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CENTRE_NS_PER_WORD = 3904;
  localparam int CENTRE_CYC_PER_WORD = CENTRE_NS_PER_WORD / CLK_PERIOD_NS;

  // Read-rate oscillator: increment and 0.0625 UI trim as a shift
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((64'(1) << NCO_W) * BIT_RATE_KHZ / CLK_KHZ);
  localparam int ADJ_SHIFT = 4;

endpackage : e1_ja_pkg

// file: e1_ja_properties.sv
`timescale 1ns/100ps
module e1_ja_properties
  import e1_ja_pkg::*;
#(
  parameter int LOS_CYC = LOS_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Line condition
  input wire logic        low_amplitude,
  input wire logic        frame_align_lost,
  input wire logic        loss_indicator_pin
);
  logic [19:0] low_cnt;
  logic        req;
  logic        done;
  logic        mapped;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Request state of the bus
  assign req    = avs_read | avs_write;
  assign done   = req & ~avs_waitrequest;
  assign mapped = avs_address inside {OFS_CTRL, OFS_STATUS,
                                      OFS_INT_STAT, OFS_INT_MASK};

  // Run length of low amplitude, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= '0;
    end else if (!low_amplitude) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + 20'h1;
    end
  end

  wait_first_a: assert property (
    req && !$past(req) |-> avs_waitrequest)
    else $error("no wait state on first request cycle");
  wait_one_a: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  wait_idle_a: assert property (
    !req |-> !avs_waitrequest)
    else $error("waitrequest high without request");
  unmapped_zero_a: assert property (
    avs_read && done && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  loss_early_a: assert property (
    $rose(loss_indicator_pin)
      |-> low_cnt >= LOS_CYC || $past(frame_align_lost))
    else $error("loss pin rose too early");
  loss_clear_a: assert property (
    (!low_amplitude && !frame_align_lost)[*6] |=> !loss_indicator_pin)
    else $error("loss pin stays high without cause");
  loss_hold_a: assert property (
    low_cnt == LOS_CYC + 8 |-> loss_indicator_pin)
    else $error("loss pin low after long low amplitude");
  los_status_a: assert property (
    done && avs_read && avs_address == OFS_STATUS && low_cnt > LOS_CYC + 8
      |-> avs_readdata[ST_LOS])
    else $error("loss status bit clear during loss");
endmodule : e1_ja_properties

bind e1_jitter_atten_fifo e1_ja_properties #(.LOS_CYC(LOS_CYC)) u_props (
  .clk(clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .low_amplitude(low_amplitude), .frame_align_lost(frame_align_lost),
  .loss_indicator_pin(loss_indicator_pin));

// file: e1_jitter_atten_fifo.sv
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Attenuator usable on transmit or receive path
// - Transmit: backplane clock writes, cleaned clock reads
// - Receive: line clock writes, dejittered clock reads
// - Depth 16 to 128 two-bit words, steps 16
// - Centre control toggle recentres the read pointer
// - Near either end, trim read rate 0.0625 UI
// - Centring bounded by 3904 ns per word
// - Select bit chooses loss pin source
// - Status bit shows loss of signal
// - Loss declared after 1 ms low amplitude
// - Equalizer gain from software or peak detector
// - Select zero: signal or frame loss; one: signal
// - Mode pins and bits choose attenuation side
module e1_jitter_atten_fifo
  import e1_ja_pkg::*;
#(
  parameter int LOS_CYC          = LOS_CYCLES,
  parameter int CENTRE_PER_WORD  = CENTRE_CYC_PER_WORD
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM register slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // Mode pins
  input  wire logic        bus_sync_mode,
  input  wire logic        bus_or_line_mode,
  // Transmit side link
  input  wire logic        backplane_clock_4m,
  input  wire logic        tx_data_in,
  output logic             tx_line_clock,
  output logic             tx_line_data,
  // Receive side link
  input  wire logic        line_rx_clock,
  input  wire logic        line_rx_data,
  output logic             extracted_clock_out,
  output logic             rx_data_out,
  // Line condition and equalizer
  input  wire logic        low_amplitude,
  input  wire logic [3:0]  peak_level,
  input  wire logic        frame_align_lost,
  output logic             loss_indicator_pin,
  output logic [3:0]       eq_gain
);

  typedef enum logic {ST_CENTRE, ST_TRACK} state_e;

  // Synchroniser bit positions
  localparam int SY_BS = 0;
  localparam int SY_BL = 1;
  localparam int SY_BPC = 2;
  localparam int SY_TXD = 3;
  localparam int SY_LNC = 4;
  localparam int SY_LND = 5;
  localparam int SY_LOW = 6;
  localparam int SY_PK = 7;
  localparam int SY_W = 11;

  typedef struct packed {
    logic [SY_W-1:0]  s1;
    logic [SY_W-1:0]  s2;
    logic             bp_prev;
    logic             ln_prev;
    logic             bp_half;
    logic             wbit;
    logic             wphase;
    logic [7:0]       wr_ptr;
    logic [7:0]       rd_ptr;
    state_e           state;
    logic [15:0]      centre_cnt;
    logic             centre_seen;
    logic [2:0]       depth_seen;
    logic [NCO_W-1:0] nco;
    logic [1:0]       shift;
    logic             rphase;
    logic             corr;
    logic             los_prev;
    logic [31:0]      ctrl;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic             ack;
    logic [31:0]      rdata;
    logic             tx_clk;
    logic             tx_dat;
    logic             rx_clk;
    logic             rx_dat;
    logic             loss;
    logic [3:0]       gain;
  } top_s;

  top_s cur;
  top_s next_cur;

  logic        los_lost;
  logic [1:0]  mem_rd;
  logic        mem_we;
  logic [1:0]  mem_wd;

  // Storage for the attenuator words
  e1_ja_mem #(
    .W     (WORD_W),
    .DEPTH (MAX_DEPTH)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (cur.wr_ptr[6:0]),
    .wr_data (mem_wd),
    .rd_addr (cur.rd_ptr[6:0]),
    .rd_data (mem_rd)
  );

  // Loss of signal timing on the synchronised amplitude flag
  e1_los_qualifier #(
    .CYCLES (LOS_CYC)
  ) u_los (
    .clk       (clk),
    .resetn    (resetn),
    .low_level (cur.s2[SY_LOW]),
    .lost      (los_lost)
  );

  // Derived control values
  logic             bl;
  logic             bs;
  logic             atten_tx;
  logic             atten_rx;
  logic [7:0]       depth;
  logic [7:0]       fill;
  logic [15:0]      centre_lim;
  logic             bp_rise;
  logic             ln_rise;
  logic             w_tick;
  logic             w_bit;
  logic [NCO_W-1:0] inc;
  logic [NCO_W:0]   nco_sum;
  logic             r_tick;
  logic             bus_hit;
  logic [31:0]      rd_mux;
  logic [INT_W-1:0] ev;
  logic [INT_W-1:0] clr;
  logic             near_full;
  logic             near_empty;

  always_comb begin
    bl = cur.s2[SY_BL];
    bs = cur.s2[SY_BS];
    // Bus sync uses the bits, line sync forces receive, free run is off
    atten_tx = bl & bs & cur.ctrl[CTL_ATTEN_EN] & cur.ctrl[CTL_SIDE_TX];
    atten_rx = bl & (~bs | (cur.ctrl[CTL_ATTEN_EN] &
                            ~cur.ctrl[CTL_SIDE_TX]));
    depth = {1'b0, cur.ctrl[CTL_DEPTH_LSB +: 3], 4'h0} +
            8'(DEPTH_STEP);
    fill = cur.wr_ptr - cur.rd_ptr;
    centre_lim = 16'(CENTRE_PER_WORD * int'(depth));
    bp_rise = cur.s2[SY_BPC] & ~cur.bp_prev;
    ln_rise = cur.s2[SY_LNC] & ~cur.ln_prev;
    // Backplane clock runs at twice the bit rate
    w_tick = atten_tx ? (bp_rise & cur.bp_half) : ln_rise;
    w_bit  = atten_tx ? cur.s2[SY_TXD] : cur.s2[SY_LND];
    near_full  = fill >= depth - GUARD_WORDS;
    near_empty = fill <= GUARD_WORDS;
    // Read rate trimmed by one sixteenth when near either end
    inc = NCO_INC;
    if (cur.state == ST_TRACK && near_full) begin
      inc = NCO_INC + (NCO_INC >> ADJ_SHIFT);
    end else if (cur.state == ST_TRACK && near_empty) begin
      inc = NCO_INC - (NCO_INC >> ADJ_SHIFT);
    end
    nco_sum = {1'b0, cur.nco} + {1'b0, inc};
    r_tick = nco_sum[NCO_W];
    bus_hit = (avs_read | avs_write) & cur.ack;
    unique case (avs_address)
      OFS_CTRL:     rd_mux = cur.ctrl;
      OFS_STATUS: begin
        rd_mux = '0;
        rd_mux[ST_LOS] = los_lost;
        rd_mux[ST_CENTRING] = (cur.state == ST_CENTRE);
        rd_mux[ST_FRAME] = frame_align_lost;
        rd_mux[ST_CORR] = cur.corr;
        rd_mux[ST_FILL_LSB +: 8] = fill;
        rd_mux[ST_GAIN_LSB +: 4] = cur.gain;
      end
      OFS_INT_STAT: rd_mux = 32'(cur.int_stat);
      OFS_INT_MASK: rd_mux = 32'(cur.int_mask);
      default:      rd_mux = '0;
    endcase
  end

  // Write a word when the second bit arrives and there is room
  assign mem_we = w_tick & cur.wphase & (fill < depth);
  assign mem_wd = {cur.wbit, w_bit};

  // Next state of the whole block
  always_comb begin
    next_cur = cur;
    ev = '0;
    clr = '0;
    // Two-stage synchronisers for the mode, link, amplitude and peak pins; frame_align_lost is used unsynchronised
    next_cur.s1 = {peak_level, low_amplitude, line_rx_data, line_rx_clock,
                   tx_data_in, backplane_clock_4m, bus_or_line_mode,
                   bus_sync_mode};
    next_cur.s2 = cur.s1;
    next_cur.bp_prev = cur.s2[SY_BPC];
    next_cur.ln_prev = cur.s2[SY_LNC];
    if (bp_rise) begin
      next_cur.bp_half = ~cur.bp_half;
    end
    // Pack serial bits into two-bit words, first bit high
    if (w_tick) begin
      next_cur.wphase = ~cur.wphase;
      next_cur.wbit = w_bit;
      if (cur.wphase && fill < depth) begin
        next_cur.wr_ptr = cur.wr_ptr + 8'h01;
      end else if (cur.wphase) begin
        ev[INT_XRUN] = 1'b1;
      end
    end
    // Read side: dejittered bit clock from the trimmed oscillator
    next_cur.nco = nco_sum[NCO_W-1:0];
    if (r_tick && cur.state == ST_TRACK) begin
      next_cur.rphase = ~cur.rphase;
      if (!cur.rphase) begin
        if (fill != 8'h00) begin
          next_cur.shift = mem_rd;
          next_cur.rd_ptr = cur.rd_ptr + 8'h01;
        end else begin
          next_cur.shift = '0;
          ev[INT_XRUN] = 1'b1;
        end
      end else begin
        next_cur.shift = {cur.shift[0], 1'b0};
      end
    end
    next_cur.corr = (cur.state == ST_TRACK) & (near_full | near_empty);
    ev[INT_CORR] = next_cur.corr & ~cur.corr;
    // Centring: restart empty, stall reads, let writes refill to half
    next_cur.centre_seen = cur.ctrl[CTL_CENTRE];
    next_cur.depth_seen = cur.ctrl[CTL_DEPTH_LSB +: 3];
    unique case (cur.state)
      ST_CENTRE: begin
        next_cur.centre_cnt = cur.centre_cnt + 16'h0001;
        if (fill >= (depth >> 1) || cur.centre_cnt >= centre_lim) begin
          next_cur.state = ST_TRACK;
          next_cur.rphase = 1'b0;
          ev[INT_CENTRED] = 1'b1;
        end
      end
      ST_TRACK: begin
        next_cur.centre_cnt = '0;
      end
    endcase
    if (cur.ctrl[CTL_CENTRE] != cur.centre_seen ||
        cur.ctrl[CTL_DEPTH_LSB +: 3] != cur.depth_seen) begin
      next_cur.state = ST_CENTRE;
      next_cur.centre_cnt = '0;
      next_cur.rd_ptr = mem_we ? cur.wr_ptr + 8'h01 : cur.wr_ptr;
    end
    // Line loss events
    next_cur.los_prev = los_lost;
    ev[INT_LOS] = los_lost & ~cur.los_prev;
    // Register bus: one wait cycle, then the transfer completes
    next_cur.ack = (avs_read | avs_write) & ~cur.ack;
    if ((avs_read | avs_write) && !cur.ack) begin
      next_cur.rdata = avs_read ? rd_mux : '0;
    end
    if (bus_hit && avs_write) begin
      unique case (avs_address)
        OFS_CTRL:     next_cur.ctrl = avs_writedata;
        OFS_INT_STAT: clr = avs_writedata[INT_W-1:0];
        OFS_INT_MASK: next_cur.int_mask = avs_writedata[INT_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_cur.int_stat = (cur.int_stat & ~clr) | ev;
    // Outputs: attenuated path while tracking, bypass otherwise, except the free-run tx clock taken from the oscillator
    if (atten_tx && cur.state == ST_TRACK) begin
      next_cur.tx_clk = cur.nco[NCO_W-1];
      next_cur.tx_dat = cur.shift[1];
    end else begin
      next_cur.tx_clk = bl ? cur.s2[SY_BPC] : cur.nco[NCO_W-1];
      next_cur.tx_dat = cur.s2[SY_TXD];
    end
    if (atten_rx && cur.state == ST_TRACK) begin
      next_cur.rx_clk = cur.nco[NCO_W-1];
      next_cur.rx_dat = cur.shift[1];
    end else begin
      next_cur.rx_clk = cur.s2[SY_LNC];
      next_cur.rx_dat = cur.s2[SY_LND];
    end
    next_cur.loss = cur.ctrl[CTL_LOSS_SEL] ? los_lost :
                    (los_lost | frame_align_lost);
    next_cur.gain = cur.ctrl[CTL_EQ_AUTO] ? cur.s2[SY_PK +: 4] :
                    cur.ctrl[CTL_GAIN_LSB +: 4];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      cur.state <= ST_CENTRE;
      cur.ctrl <= CTRL_RESET;
      cur.depth_seen <= CTRL_RESET[CTL_DEPTH_LSB +: 3];
    end else begin
      cur <= next_cur;
    end
  end

  // Port drive
  assign avs_readdata        = cur.rdata;
  assign avs_waitrequest     = (avs_read | avs_write) & ~cur.ack;
  assign irq                 = |(cur.int_stat & cur.int_mask);
  assign tx_line_clock       = cur.tx_clk;
  assign tx_line_data        = cur.tx_dat;
  assign extracted_clock_out = cur.rx_clk;
  assign rx_data_out         = cur.rx_dat;
  assign loss_indicator_pin  = cur.loss;
  assign eq_gain             = cur.gain;

endmodule : e1_jitter_atten_fifo

// file: e1_line_model.sv
`timescale 1ns/100ps
module e1_line_model (
  // Level each side sends
  input  wire logic tx_level,
  input  wire logic rx_level,
  // Link lines
  output logic      backplane_clock_4m,
  output logic      tx_data_in,
  output logic      line_rx_clock,
  output logic      line_rx_data
);
  // Free running link clocks, 200 ns, phases unrelated to clk
  initial begin
    backplane_clock_4m = 1'b0;
    #37;
    forever #100 backplane_clock_4m = ~backplane_clock_4m;
  end
  initial begin
    line_rx_clock = 1'b0;
    #81;
    forever #100 line_rx_clock = ~line_rx_clock;
  end
  // Data moves on the falling edge, stable at the rising edge
  initial tx_data_in = 1'b0;
  initial line_rx_data = 1'b0;
  always @(negedge backplane_clock_4m) tx_data_in <= tx_level;
  always @(negedge line_rx_clock) line_rx_data <= rx_level;
endmodule : e1_line_model

// file: e1_los_qualifier.sv
`timescale 1ns/100ps
module e1_los_qualifier
  import e1_ja_pkg::*;
#(
  parameter int CYCLES = LOS_CYCLES,
  parameter int CW     = $clog2(CYCLES + 1)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Low amplitude level, already synchronised
  input  wire logic low_level,
  output logic      lost
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lost;
  } los_s;

  los_s cur;
  los_s next_cur;

  // Declare loss only after the low level has lasted the full time
  always_comb begin
    next_cur = cur;
    if (!low_level) begin
      next_cur.cnt  = '0;
      next_cur.lost = 1'b0;
    end else if (cur.cnt >= CW'(CYCLES - 1)) begin
      next_cur.lost = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign lost = cur.lost;

endmodule : e1_los_qualifier

// file: tb_e1_jitter_atten_fifo.sv
`timescale 1ns/100ps
module tb_e1_jitter_atten_fifo
  import e1_ja_pkg::*;
;
  localparam int LOSC = 50;
  localparam int CPW  = 20;
  // Design side signals
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        bus_sync_mode = 1'b1;
  logic        bus_or_line_mode = 1'b1;
  logic        backplane_clock_4m;
  logic        tx_data_in;
  logic        tx_line_clock;
  logic        tx_line_data;
  logic        line_rx_clock;
  logic        line_rx_data;
  logic        extracted_clock_out;
  logic        rx_data_out;
  logic        low_amplitude = 1'b0;
  logic [3:0]  peak_level = 4'h9;
  logic        frame_align_lost = 1'b0;
  logic        loss_indicator_pin;
  logic [3:0]  eq_gain;
  // Bench state
  logic        tx_level = 1'b0;
  logic        rx_level = 1'b0;
  logic [31:0] q;
  logic [31:0] ctl;
  int          ntx;
  int          nrx;
  int          miscompares = 0;
  int          n_compared = 0;

  // System clock
  always #12.5 clk = ~clk;

  e1_jitter_atten_fifo #(.LOS_CYC(LOSC), .CENTRE_PER_WORD(CPW)) u_dut (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .bus_sync_mode(bus_sync_mode), .bus_or_line_mode(bus_or_line_mode),
    .backplane_clock_4m(backplane_clock_4m), .tx_data_in(tx_data_in),
    .tx_line_clock(tx_line_clock), .tx_line_data(tx_line_data),
    .line_rx_clock(line_rx_clock), .line_rx_data(line_rx_data),
    .extracted_clock_out(extracted_clock_out), .rx_data_out(rx_data_out),
    .low_amplitude(low_amplitude), .peak_level(peak_level),
    .frame_align_lost(frame_align_lost),
    .loss_indicator_pin(loss_indicator_pin), .eq_gain(eq_gain));

  e1_line_model u_line (
    .tx_level(tx_level), .rx_level(rx_level),
    .backplane_clock_4m(backplane_clock_4m), .tx_data_in(tx_data_in),
    .line_rx_clock(line_rx_clock), .line_rx_data(line_rx_data));

  // Verdict and end of run
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One Avalon-MM access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20 && avs_waitrequest !== 1'b0) begin
      miscompares++;
      complete_run();
    end
  endtask : bus

  task automatic rd_chk(input string name, input logic [4:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, q & m, exp);
  endtask : rd_chk

  // Read until the masked value matches, bounded
  task automatic poll(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] v, input int lim);
    int t;
    t = 0;
    do begin
      bus(1'b0, a, 32'h0);
      t++;
    end while ((q & m) !== v && t < lim);
    if ((q & m) !== v) begin
      miscompares++;
      complete_run();
    end
  endtask : poll

  // Rising edges of both clock outputs over 400 cycles
  task automatic clk_rate(output int et, output int er);
    logic pt;
    logic pr;
    et = 0;
    er = 0;
    pt = tx_line_clock;
    pr = extracted_clock_out;
    repeat (400) begin
      @(posedge clk);
      et += int'(tx_line_clock & ~pt);
      er += int'(extracted_clock_out & ~pr);
      pt = tx_line_clock;
      pr = extracted_clock_out;
    end
  endtask : clk_rate

  // Main sequence
  initial begin
    cyc(12);
    resetn <= 1'b1;
    rd_chk("ctrl", OFS_CTRL, '1, CTRL_RESET);
    rd_chk("mask", OFS_INT_MASK, '1, 32'h0);
    bus(1'b1, 5'h10, 32'hffffffff);
    rd_chk("unmapped", 5'h10, '1, 32'h0);
    rd_chk("ctrl kept", OFS_CTRL, '1, CTRL_RESET);
    // Every depth code recentres in bound at half depth
    for (int c = 0; c < 8; c++) begin
      ctl = 32'h1 | (32'(c) << CTL_DEPTH_LSB);
      bus(1'b1, OFS_CTRL, ctl);
      rd_chk("centring", OFS_STATUS, 32'h2, 32'h2);
      poll(OFS_STATUS, 32'h2, 32'h0, CPW * (c + 1) * 16 / 3 + 4);
      check("fill", 32'(q[15:8] >= 8'((c + 1) * 8 - 1)
                        && q[15:8] <= 8'((c + 1) * 8 + 1)), 32'h1);
    end
    // Writes outrun reads, so the rate trim starts
    bus(1'b1, OFS_INT_STAT, 32'h2);
    poll(OFS_STATUS, 32'h8, 32'h8, 1000);
    rd_chk("trim event", OFS_INT_STAT, 32'h2, 32'h2);
    // Centring event raises irq only when unmasked
    check("irq masked", 32'(irq), 32'h0);
    bus(1'b1, OFS_INT_MASK, 32'h4);
    cyc(1);
    check("irq on", 32'(irq), 32'h1);
    bus(1'b1, OFS_INT_STAT, 32'h4);
    cyc(1);
    check("irq cleared", 32'(irq), 32'h0);
    // Toggling the centre control recentres
    ctl = ctl ^ (32'h1 << CTL_CENTRE);
    bus(1'b1, OFS_CTRL, ctl);
    rd_chk("recentre", OFS_STATUS, 32'h2, 32'h2);
    poll(OFS_STATUS, 32'h2, 32'h0, CPW * 128 / 3 + 4);
    cyc(1);
    check("irq again", 32'(irq), 32'h1);
    bus(1'b1, OFS_INT_STAT, 32'h4);
    // Frame loss reaches the pin only with select at zero
    frame_align_lost <= 1'b1;
    cyc(4);
    check("pin frame", 32'(loss_indicator_pin), 32'h1);
    ctl = ctl | (32'h1 << CTL_LOSS_SEL);
    bus(1'b1, OFS_CTRL, ctl);
    cyc(3);
    check("pin no frame", 32'(loss_indicator_pin), 32'h0);
    frame_align_lost <= 1'b0;
    // Loss of signal only after the qualifying time
    low_amplitude <= 1'b1;
    cyc(LOSC / 2);
    rd_chk("los early", OFS_STATUS, 32'h1, 32'h0);
    cyc(LOSC);
    rd_chk("los", OFS_STATUS, 32'h1, 32'h1);
    check("pin los", 32'(loss_indicator_pin), 32'h1);
    rd_chk("los event", OFS_INT_STAT, 32'h1, 32'h1);
    low_amplitude <= 1'b0;
    cyc(8);
    rd_chk("los gone", OFS_STATUS, 32'h1, 32'h0);
    // Software gain reaches the equalizer
    bus(1'b1, OFS_CTRL, ctl | (32'h5 << CTL_GAIN_LSB));
    cyc(2);
    check("gain", 32'(eq_gain), 32'h5);
    // Automatic gain follows the peak detector
    bus(1'b1, OFS_CTRL, ctl | (32'h1 << CTL_EQ_AUTO));
    cyc(2);
    check("auto gain", 32'(eq_gain), 32'h9);
    rd_chk("gain status", OFS_STATUS, 32'hf_0000, 32'h9_0000);
    // Data passes on each path: rx, tx, free run, line sync
    for (int m = 0; m < 4; m++) begin
      bus_or_line_mode <= (m != 2);
      bus_sync_mode <= (m != 3);
      bus(1'b1, OFS_CTRL, 32'h1 | (32'(m & 1) << CTL_SIDE_TX));
      for (int l = 0; l < 2; l++) begin
        tx_level <= l[0];
        rx_level <= l[0];
        cyc(1500);
        check("rx data", 32'(rx_data_out), 32'(l));
        check("tx data", 32'(tx_line_data), 32'(l));
      end
      // Attenuated clocks run near the bit rate, bypassed ones faster, except the free-run tx clock from the oscillator
      clk_rate(ntx, nrx);
      check("tx clock fast", 32'(ntx > 30), 32'(m == 0 || m == 3));
      check("rx clock fast", 32'(nrx > 30), 32'(m == 1 || m == 2));
    end
    complete_run();
  end
endmodule : tb_e1_jitter_atten_fifo
